// *** rtl/wtop_port.v ***
// Waypoint trace output ports, one per core, with an APB control slave
`timescale 1ns/1ps
`include "wtop_map.vh"
module wtop_port #(
    parameter NC = 2,
    parameter CNT_W = 4
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`WTOP_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [NC-1:0] ev_valid,
    input wire [3*NC-1:0] ev_kind,
    input wire [4*NC-1:0] ev_exc,
    input wire [32*NC-1:0] ev_pc,
    input wire [32*NC-1:0] ev_target,
    input wire [NC-1:0] ev_tbit,
    input wire [NC-1:0] ev_jbit,
    input wire [NC-1:0] ev_cur_compact,
    input wire [NC-1:0] ev_wide,
    input wire [NC-1:0] ev_link,
    input wire [NC-1:0] ev_passed,
    input wire [NC-1:0] ev_ns_bit,
    input wire [NC-1:0] ev_monitor,
    input wire [32*NC-1:0] ev_ctx,
    input wire [NC-1:0] ev_prohibit,
    input wire [NC-1:0] ev_serial,
    input wire [2*NC-1:0] ev_commit,
    input wire [NC-1:0] ev_flush,
    input wire [NC-1:0] noninvasive_debug_allow,
    input wire [NC-1:0] invasive_debug_allow,
    input wire [NC-1:0] wp_output_enable,
    output wire [NC-1:0] wp_confirmed,
    output wire [3*NC-1:0] wp_kind,
    output wire [4*NC-1:0] wp_exc_kind,
    output wire [32*NC-1:0] wp_last_exec_addr,
    output wire [32*NC-1:0] wp_dest_addr,
    output wire [NC-1:0] wp_dest_compact_state,
    output wire [NC-1:0] wp_dest_jazelle_state,
    output wire [NC-1:0] wp_wide_instr_size,
    output wire [NC-1:0] wp_link_update,
    output wire [NC-1:0] wp_cond_passed,
    output wire [NC-1:0] wp_nonsecure_state,
    output wire [32*NC-1:0] wp_context_ident,
    output wire [NC-1:0] wp_trace_blocked,
    output wire [2*NC-1:0] wp_commit_count,
    output wire [NC-1:0] wp_discard_pending,
    output wire [NC-1:0] wp_queue_empty_n
);

    // =========================================
    // Helpers
    function is_branch;
        input [2:0] k;
        begin
            is_branch = (k == `WTOP_KIND_DIRECT) ||
                        (k == `WTOP_KIND_INDIRECT);
        end
    endfunction

    function is_entry;
        input [2:0] k;
        begin
            is_entry = (k == `WTOP_KIND_ENTRY);
        end
    endfunction

    function is_exit;
        input [2:0] k;
        begin
            is_exit = (k == `WTOP_KIND_EXIT);
        end
    endfunction

    // =========================================
    // Debug allow synchronisers
    reg [NC-1:0] nid_meta_ff;
    reg [NC-1:0] nid_sync_ff;
    reg [NC-1:0] dbg_meta_ff;
    reg [NC-1:0] dbg_sync_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nid_meta_ff <= {NC{1'b0}};
            nid_sync_ff <= {NC{1'b0}};
            dbg_meta_ff <= {NC{1'b0}};
            dbg_sync_ff <= {NC{1'b0}};
        end else begin
            nid_meta_ff <= noninvasive_debug_allow;
            nid_sync_ff <= nid_meta_ff;
            dbg_meta_ff <= invasive_debug_allow;
            dbg_sync_ff <= dbg_meta_ff;
        end
    end

    // =========================================
    // APB slave
    reg [NC-1:0] lane_en_ff;
    wire [NC-1:0] blk_vec;
    wire [NC-1:0] empty_vec;
    wire apb_setup;
    wire apb_write;
    wire map_ctrl;
    wire map_stat;

    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pready & pwrite;
    assign map_ctrl = (paddr == `WTOP_CTRL_OFS);
    assign map_stat = (paddr == `WTOP_STAT_OFS);

    // No wait state; pready rises in the first access cycle, and every bus output still comes from a flip-flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            lane_en_ff <= {NC{`WTOP_CTRL_RESET}};
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~(map_ctrl | (map_stat & ~pwrite));
            prdata <= 32'h00000000;
            if (apb_setup & ~pwrite & map_ctrl) begin
                prdata[NC-1:0] <= lane_en_ff;
            end
            if (apb_setup & ~pwrite & map_stat) begin
                prdata[NC-1:0] <= blk_vec;
                prdata[`WTOP_STAT_EMPTY_POS+NC-1:`WTOP_STAT_EMPTY_POS]
                    <= empty_vec;
            end
            if (apb_write & map_ctrl & ~pslverr) begin
                lane_en_ff <= pwdata[NC-1:0];
            end
        end
    end

    // =========================================
    // Per-core waypoint lanes
    genvar c;
    generate
        for (c = 0; c < NC; c = c + 1) begin : g_lane
            wire e_v;
            wire [2:0] kind;
            wire [3:0] exc;
            wire k_exc;
            wire k_bad;
            wire is_rst;
            wire seq_ok;
            wire gate;
            wire go_block;
            wire resume;
            reg emit;
            wire plain_entry;
            reg allow_ff;
            reg nxt_allow;
            reg blk_ff;
            reg open_ff;
            reg val_ff;
            reg [2:0] kind_ff;
            reg [3:0] exc_ff;
            reg [31:0] pc_ff;
            reg [31:0] dest_ff;
            reg tbit_ff;
            reg jbit_ff;
            reg wide_ff;
            reg link_ff;
            reg pass_ff;
            reg ns_ff;
            reg [31:0] ctx_ff;
            reg [31:0] nxt_dest;

            // =========================================
            // Waypoint decode
            assign e_v = ev_valid[c];
            assign kind = ev_kind[3*c+:3];
            assign exc = ev_exc[4*c+:4];
            assign k_exc = (kind == `WTOP_KIND_EXC);
            assign k_bad = (kind[2:1] == `WTOP_KIND_BAD_HI);
            assign is_rst = k_exc & (exc == `WTOP_EXC_RESET);
            assign plain_entry = is_entry(kind) & ~ev_prohibit[c];
            // Stray entry or exit would break the pairing
            assign seq_ok = plain_entry ? ~open_ff :
                            is_exit(kind) ? open_ff :
                            1'b1;
            assign gate = wp_output_enable[c] & lane_en_ff[c];

            // =========================================
            // Allow latch
            // Allow inputs take effect only at an exception or a serialising point
            always @* begin
                nxt_allow = allow_ff;
                if (e_v & (k_exc | ev_serial[c])) begin
                    nxt_allow = nid_sync_ff[c] | dbg_sync_ff[c];
                end
            end

            assign go_block = e_v & ~blk_ff & ~k_bad &
                              (ev_prohibit[c] | ~nxt_allow);
            assign resume = e_v & blk_ff & ~k_bad & ~is_rst &
                            ~ev_prohibit[c] & nxt_allow;
            // Blocked waypoint goes out once even mid session; any
            // other needs a clear lane and a legal entry/exit order
            always @* begin
                emit = 1'b0;
                if (gate & e_v & ~k_bad & ~is_rst) begin
                    if (go_block) begin
                        emit = 1'b1;
                    end else if (seq_ok & (~blk_ff | resume)) begin
                        emit = 1'b1;
                    end
                end
            end

            // =========================================
            // Destination masking
            always @* begin
                nxt_dest = ev_target[32*c+:32];
                if (!ev_tbit[c]) begin
                    nxt_dest[1] = 1'b0;
                end
                if (!ev_jbit[c]) begin
                    nxt_dest[0] = 1'b0;
                end
                if (go_block | is_entry(kind)) begin
                    nxt_dest = 32'h00000000;
                end
            end

            // =========================================
            // Lane registers
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    allow_ff <= 1'b1;
                    blk_ff <= 1'b0;
                    open_ff <= 1'b0;
                    val_ff <= 1'b0;
                    kind_ff <= `WTOP_KIND_DIRECT;
                    exc_ff <= 4'h0;
                    pc_ff <= 32'h00000000;
                    dest_ff <= 32'h00000000;
                    tbit_ff <= 1'b0;
                    jbit_ff <= 1'b0;
                    wide_ff <= 1'b0;
                    link_ff <= 1'b0;
                    pass_ff <= 1'b0;
                    ns_ff <= 1'b0;
                    ctx_ff <= 32'h00000000;
                end else begin
                    allow_ff <= nxt_allow;
                    // Level stays up while blocked, strobe shows it once
                    if (go_block) begin
                        blk_ff <= 1'b1;
                    end else if (resume) begin
                        blk_ff <= 1'b0;
                    end
                    val_ff <= emit;
                    if (emit & ~go_block & plain_entry) begin
                        open_ff <= 1'b1;
                    end else if (emit & ~go_block & is_exit(kind)) begin
                        open_ff <= 1'b0;
                    end
                    if (emit) begin
                        kind_ff <= go_block ? `WTOP_KIND_ENTRY :
                                   kind;
                        exc_ff <= exc;
                        pc_ff <= ev_pc[32*c+:32];
                        dest_ff <= nxt_dest;
                        tbit_ff <= ev_tbit[c] & ~go_block;
                        jbit_ff <= ev_jbit[c] & ~go_block;
                        wide_ff <= ev_wide[c] & ev_cur_compact[c];
                        link_ff <= ev_link[c] & is_branch(kind) &
                                   ~go_block;
                        pass_ff <= is_branch(kind) & ~go_block ?
                                   ev_passed[c] : 1'b1;
                        ns_ff <= ev_ns_bit[c] & ~ev_monitor[c];
                        ctx_ff <= ev_ctx[32*c+:32];
                    end
                end
            end

            // =========================================
            // Commit tracking
            wtop_spec_track #(
                .CNT_W(CNT_W)
            ) u_track (
                .pclk(pclk),
                .presetn(presetn),
                .push(emit),
                .commit_req(ev_commit[2*c+:2]),
                .flush(ev_flush[c]),
                .commit_ff(wp_commit_count[2*c+:2]),
                .flush_ff(wp_discard_pending[c]),
                .empty_n_ff(wp_queue_empty_n[c])
            );

            // =========================================
            // Outputs come straight from the lane flip-flops
            assign wp_confirmed[c] = val_ff;
            assign wp_kind[3*c+:3] = kind_ff;
            assign wp_exc_kind[4*c+:4] = exc_ff;
            assign wp_last_exec_addr[32*c+:32] = pc_ff;
            assign wp_dest_addr[32*c+:32] = dest_ff;
            assign wp_dest_compact_state[c] = tbit_ff;
            assign wp_dest_jazelle_state[c] = jbit_ff;
            assign wp_wide_instr_size[c] = wide_ff;
            assign wp_link_update[c] = link_ff;
            assign wp_cond_passed[c] = pass_ff;
            assign wp_nonsecure_state[c] = ns_ff;
            assign wp_context_ident[32*c+:32] = ctx_ff;
            assign wp_trace_blocked[c] = blk_ff;
            assign blk_vec[c] = blk_ff;
            assign empty_vec[c] = ~wp_queue_empty_n[c];
        end
    endgenerate
endmodule // wtop_port

// *** common/wtop_map.vh ***
// Constants for the waypoint trace output port
`ifndef WTOP_MAP_VH
`define WTOP_MAP_VH
// =========================================
// Register offsets and fields
`define WTOP_ADDR_W 12
`define WTOP_CTRL_OFS 12'h000
`define WTOP_STAT_OFS 12'h004
`define WTOP_STAT_EMPTY_POS 16
`define WTOP_CTRL_RESET 1'b1
// =========================================
// Waypoint kinds
`define WTOP_KIND_DIRECT 3'h0
`define WTOP_KIND_INDIRECT 3'h1
`define WTOP_KIND_EXC 3'h2
`define WTOP_KIND_BARRIER 3'h3
`define WTOP_KIND_ENTRY 3'h4
`define WTOP_KIND_EXIT 3'h5
`define WTOP_KIND_BAD_HI 2'h3
// =========================================
// Exception kinds
`define WTOP_EXC_HALT_DEBUG 4'h1
`define WTOP_EXC_MONITOR 4'h2
`define WTOP_EXC_IMPRECISE 4'h4
`define WTOP_EXC_ENV_TRAP 4'h5
`define WTOP_EXC_RESET 4'h8
`define WTOP_EXC_UNDEF 4'h9
`define WTOP_EXC_PREFETCH 4'hB
`define WTOP_EXC_PRECISE 4'hC
`define WTOP_EXC_IRQ 4'hE
`define WTOP_EXC_FIQ 4'hF
`endif

// *** rtl/wtop_spec_track.v ***
// Speculative waypoint count, commit and discard tracking for one core
`timescale 1ns/1ps
module wtop_spec_track #(
    parameter CNT_W = 4
) (
    input wire pclk,
    input wire presetn,
    input wire push,
    input wire [1:0] commit_req,
    input wire flush,
    output reg [1:0] commit_ff,
    output reg flush_ff,
    output reg empty_n_ff
);
    reg [CNT_W-1:0] cnt_ff;
    reg [CNT_W-1:0] avail;
    reg [CNT_W-1:0] nxt_cnt;
    reg [1:0] nxt_commit;

    // =========================================
    // Count update
    always @* begin
        avail = cnt_ff + {{(CNT_W-1){1'b0}}, push};
        // Never commit more than is queued, so the count cannot wrap below zero
        if ({{(CNT_W-2){1'b0}}, commit_req} > avail) begin
            nxt_commit = avail[1:0];
        end else begin
            nxt_commit = commit_req;
        end
        nxt_cnt = avail - {{(CNT_W-2){1'b0}}, nxt_commit};
        if (flush) begin
            nxt_cnt = {CNT_W{1'b0}};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= {CNT_W{1'b0}};
            commit_ff <= 2'h0;
            flush_ff <= 1'b0;
            empty_n_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            commit_ff <= nxt_commit;
            flush_ff <= flush;
            empty_n_ff <= (nxt_cnt != {CNT_W{1'b0}});
        end
    end
endmodule // wtop_spec_track

// *** bench/wtop_monitor.sv ***
// Checker on the core 0 lane of the waypoint port
`timescale 1ns/1ps
`include "wtop_map.vh"
module wtop_monitor #(
    parameter NC = 2,
    parameter CNT_W = 4
) (
    input wire pclk,
    input wire presetn,
    input wire [NC-1:0] ev_valid,
    input wire [3*NC-1:0] ev_kind,
    input wire [4*NC-1:0] ev_exc,
    input wire [2*NC-1:0] ev_commit,
    input wire [NC-1:0] ev_flush,
    input wire [NC-1:0] wp_output_enable,
    input wire [NC-1:0] wp_confirmed,
    input wire [3*NC-1:0] wp_kind,
    input wire [32*NC-1:0] wp_dest_addr,
    input wire [NC-1:0] wp_dest_compact_state,
    input wire [NC-1:0] wp_dest_jazelle_state,
    input wire [NC-1:0] wp_link_update,
    input wire [NC-1:0] wp_cond_passed,
    input wire [NC-1:0] wp_trace_blocked,
    input wire [2*NC-1:0] wp_commit_count,
    input wire [NC-1:0] wp_discard_pending,
    input wire [NC-1:0] wp_queue_empty_n
);
    // =========================================
    // Sequences
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_flush;
        ev_flush[0] && !ev_valid[0];
    endsequence
    sequence s_blk_wp;
        wp_confirmed[0] && wp_trace_blocked[0];
    endsequence
    // =========================================
    // Assertions
    chk_kind_legal: assert property (
        wp_confirmed[0] |-> wp_kind[2:1] != 2'h3) else $error("bad kind");
    chk_link_branch: assert property (
        wp_confirmed[0] && wp_link_update[0] |-> wp_kind[2:1] == 2'h0)
        else $error("link on non-branch");
    chk_taken_forced: assert property (
        wp_confirmed[0] && wp_kind[2:1] != 2'h0 |-> wp_cond_passed[0])
        else $error("passed not forced");
    chk_blocked_zero: assert property (
        s_blk_wp |-> wp_dest_addr[31:0] == 32'h0 && wp_kind[2:0] == 3'h4
        && !wp_dest_compact_state[0] && !wp_dest_jazelle_state[0])
        else $error("blocked fields wrong");
    chk_dest_align: assert property (
        wp_confirmed[0] |-> (wp_dest_compact_state[0] || !wp_dest_addr[1])
        && (wp_dest_jazelle_state[0] || !wp_dest_addr[0]))
        else $error("dest not aligned");
    chk_blocked_once: assert property (
        s_blk_wp |-> !$past(wp_trace_blocked[0])) else $error("blocked twice");
    chk_enable_gate: assert property (
        !wp_output_enable[0] |=> !wp_confirmed[0]) else $error("not enabled");
    chk_confirm_cause: assert property (
        wp_confirmed[0] |-> $past(ev_valid[0])) else $error("stray strobe");
    chk_reset_untraced: assert property (
        ev_valid[0] && ev_kind[2:0] == 3'h2 && ev_exc[3:0] == `WTOP_EXC_RESET
        |=> !wp_confirmed[0]) else $error("reset traced");
    chk_flush_clear: assert property (
        s_flush |=> wp_discard_pending[0] && !wp_queue_empty_n[0])
        else $error("flush not cleared");
    chk_commit_bound: assert property (
        wp_commit_count[1:0] <= $past(ev_commit[1:0])) else $error("commits");
endmodule // wtop_monitor
bind wtop_port wtop_monitor #(.NC(NC), .CNT_W(CNT_W)) wtop_monitor_inst (.*);

// *** bench/wtop_trace_rx.sv ***
// Trace receiver model: enable, pending count, resync
`timescale 1ns/1ps
module wtop_trace_rx #(
    parameter NC = 2
) (
    input wire pclk,
    input wire presetn,
    input wire [NC-1:0] allow,
    input wire [NC-1:0] wp_confirmed,
    input wire [NC-1:0] wp_trace_blocked,
    input wire [NC-1:0] wp_discard_pending,
    input wire [2*NC-1:0] wp_commit_count,
    output logic [NC-1:0] wp_output_enable,
    output int pend0,
    output int isync0
);
    logic need_sync;
    // =========================================
    // Plain level, no handshake back to the core
    assign wp_output_enable = allow;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend0 <= 0;
            isync0 <= 0;
            need_sync <= 1'b0;
        end else begin
            if (wp_discard_pending[0])
                pend0 <= 0;
            else
                pend0 <= pend0 + wp_confirmed[0] - wp_commit_count[1:0];
            if (wp_confirmed[0] && wp_trace_blocked[0]) begin
                need_sync <= 1'b1;
            end else if (wp_confirmed[0] && need_sync) begin
                isync0 <= isync0 + 1;
                need_sync <= 1'b0;
            end
        end
    end
endmodule // wtop_trace_rx

// *** bench/wtop_port_bench.sv ***
// Self-checking bench for the waypoint trace output port
`timescale 1ns/1ps
module wtop_port_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] ev_valid, ev_tbit, ev_jbit, ev_cur_compact, ev_wide, ev_link;
    logic [1:0] ev_passed, ev_ns_bit, ev_monitor, ev_prohibit, ev_serial;
    logic [1:0] ev_flush, noninvasive_debug_allow, invasive_debug_allow;
    logic [1:0] wp_output_enable, allow, wp_confirmed, wp_dest_compact_state;
    logic [1:0] wp_dest_jazelle_state, wp_wide_instr_size, wp_link_update;
    logic [1:0] wp_cond_passed, wp_nonsecure_state, wp_trace_blocked;
    logic [1:0] wp_discard_pending, wp_queue_empty_n;
    logic [5:0] ev_kind, wp_kind;
    logic [7:0] ev_exc, wp_exc_kind;
    logic [3:0] ev_commit, wp_commit_count;
    logic [63:0] ev_pc, ev_target, ev_ctx, wp_last_exec_addr, wp_dest_addr;
    logic [63:0] wp_context_ident;
    logic [3:0] excs [10] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'hB, 4'hC,
        4'hE, 4'hF};
    int num_errors, num_checks, pend0, isync0;
    wtop_port wtop_port_inst (.*);
    wtop_trace_rx wtop_trace_rx_inst (.*);
    always #2.5 pclk = ~pclk;
    // =========================================
    // Shared tasks
    task close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            close_out;
        end
    endtask
    // f holds monitor, prohibit, link, passed, T, J
    task send(input int c, input logic [2:0] k, input logic [3:0] x,
              input logic [31:0] tg, input logic [5:0] f);
        @(posedge pclk);
        ev_valid[c] <= 1'b1;
        ev_kind[c*3+:3] <= k;
        ev_exc[c*4+:4] <= x;
        ev_target[c*32+:32] <= tg;
        ev_pc[c*32+:32] <= tg ^ 32'h100;
        ev_ctx[c*32+:32] <= ~tg;
        {ev_monitor[c], ev_prohibit[c], ev_link[c], ev_passed[c], ev_tbit[c],
            ev_jbit[c]} <= f;
        @(posedge pclk);
        ev_valid[c] <= 1'b0;
        #1;
    endtask
    task wp(input logic [2:0] k, input logic [3:0] x, input logic [31:0] tg,
            input logic [5:0] f, input logic cf, input logic bk);
        logic [2:0] ek;
        ek = bk ? 3'h4 : k;
        send(0, k, x, tg, f);
        chk(wp_confirmed[0], cf);
        if (cf) begin
            chk(wp_kind[2:0], ek);
            chk(wp_trace_blocked[0], bk);
            chk(wp_dest_addr[31:0], (ek == 3'h4) ? 32'h0 :
                {tg[31:2], tg[1] & f[1], tg[0] & f[0]});
            chk({wp_dest_compact_state[0], wp_dest_jazelle_state[0]},
                bk ? 2'h0 : f[1:0]);
            chk(wp_cond_passed[0], ek[2] | ek[1] | f[2]);
            chk(wp_link_update[0], ~(ek[2] | ek[1]) & f[3]);
            chk(wp_last_exec_addr[31:0], tg ^ 32'h100);
            chk(wp_context_ident[31:0], ~tg);
            chk(wp_nonsecure_state[0], ev_ns_bit[0] & ~f[5]);
            chk(wp_wide_instr_size[0], ev_cur_compact[0]);
            chk(wp_queue_empty_n[0], 1'b1);
            if (ek == 3'h2) chk(wp_exc_kind[3:0], x);
            @(posedge pclk);
            ev_commit[1:0] <= 2'h1;
            @(posedge pclk);
            ev_commit[1:0] <= 2'h0;
            #1;
            chk(wp_commit_count[1:0], 2'h1);
            chk(wp_queue_empty_n[0], 1'b0);
        end
    endtask
    // =========================================
    // Scenarios
    task t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h3);
        chk(er, 1'b0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h30000);
        chk(er, 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, 12'h004, 32'hFFFFFFFF);
        chk(er, 1'b1);
        chk(wp_queue_empty_n, 2'h0);
    endtask
    task t_kinds;
        for (int k = 0; k < 8; k++)
            wp(k, 4'h0, 32'h80012343 ^ (k << 8),
               {k[1], 2'b01, ~k[0], k[0], k[0]}, k < 6, 1'b0);
        wp(3'h5, 4'h0, 32'h80012000, 6'b000100, 1'b0, 1'b0);
        wp(3'h4, 4'h0, 32'h80012010, 6'b000100, 1'b1, 1'b0);
        wp(3'h4, 4'h0, 32'h80012020, 6'b000100, 1'b0, 1'b0);
        wp(3'h5, 4'h0, 32'h80012030, 6'b000100, 1'b1, 1'b0);
        @(posedge pclk);
        {ev_cur_compact[0], ev_ns_bit[0]} <= 2'h0;
        for (int i = 0; i < 10; i++)
            wp(3'h2, excs[i], 32'h40000003 + i * 16, 6'b001100,
               excs[i] != 4'h8, 1'b0);
        @(posedge pclk);
        {ev_cur_compact[0], ev_ns_bit[0]} <= 2'h3;
    endtask
    task t_block;
        wp(3'h0, 4'h0, 32'h50000003, 6'b010111, 1'b1, 1'b1);
        wp(3'h0, 4'h0, 32'h50000007, 6'b010111, 1'b0, 1'b0);
        wp(3'h0, 4'h0, 32'h5000000B, 6'b000111, 1'b1, 1'b0);
        chk(isync0, 1);
        @(posedge pclk);
        {noninvasive_debug_allow[0], invasive_debug_allow[0]} <= 2'h0;
        // Pins pass a two-stage sync before the latch sees them
        repeat (3) @(posedge pclk);
        wp(3'h2, 4'hE, 32'h60000000, 6'b000100, 1'b1, 1'b1);
        wp(3'h1, 4'h0, 32'h60000010, 6'b000100, 1'b0, 1'b0);
        @(posedge pclk);
        {noninvasive_debug_allow[0], invasive_debug_allow[0]} <= 2'h3;
        repeat (3) @(posedge pclk);
        // Pins alone change nothing until an exception or serialising waypoint
        wp(3'h0, 4'h0, 32'h60000014, 6'b000100, 1'b0, 1'b0);
        @(posedge pclk);
        ev_serial[0] <= 1'b1;
        wp(3'h1, 4'h0, 32'h60000020, 6'b000100, 1'b1, 1'b0);
        @(posedge pclk);
        ev_serial[0] <= 1'b0;
        chk(isync0, 2);
    endtask
    task t_enable;
        @(posedge pclk);
        allow[0] <= 1'b0;
        wp(3'h0, 4'h0, 32'h70000000, 6'b000100, 1'b0, 1'b0);
        @(posedge pclk);
        allow[0] <= 1'b1;
        apb(1'b1, 12'h000, 32'h2);
        wp(3'h0, 4'h0, 32'h70000004, 6'b000100, 1'b0, 1'b0);
        send(1, 3'h3, 4'h0, 32'h70000008, 6'b000100);
        chk(wp_confirmed, 2'h2);
        apb(1'b1, 12'h000, 32'h3);
        wp(3'h3, 4'h0, 32'h7000000C, 6'b000100, 1'b1, 1'b0);
    endtask
    task t_flush;
        send(0, 3'h0, 4'h0, 32'h1, 6'b000100);
        send(0, 3'h1, 4'h0, 32'h2, 6'b000100);
        @(posedge pclk);
        ev_commit[1:0] <= 2'h1;
        ev_flush[0] <= 1'b1;
        @(posedge pclk);
        ev_commit[1:0] <= 2'h0;
        ev_flush[0] <= 1'b0;
        #1;
        chk(wp_commit_count[1:0], 2'h1);
        chk({wp_discard_pending[0], wp_queue_empty_n[0]}, 2'h2);
        @(posedge pclk);
        #1;
        chk(pend0, 0);
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, ev_valid} = '0;
        {ev_tbit, ev_jbit, ev_link, ev_passed, ev_monitor, ev_prohibit} = '0;
        {ev_serial, ev_flush, ev_kind, ev_exc, ev_commit, ev_pc} = '0;
        {ev_target, ev_ctx} = '0;
        {ev_cur_compact, ev_wide, ev_ns_bit, allow} = '1;
        {noninvasive_debug_allow, invasive_debug_allow} = '1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_kinds;
        t_block;
        t_enable;
        t_flush;
        close_out;
    end
endmodule // wtop_port_bench
